// file: common/sfct_params.svh
// Constants of the SPI frame and check target.
// Included by the package user files; defines only.
`ifndef SFCT_PARAMS_SVH
`define SFCT_PARAMS_SVH

`define SFCT_FRAME_LONG 6'd32
`define SFCT_FRAME_SHORT 6'd24
`define SFCT_EDGE_MAX 6'd63
`define SFCT_CRC_POLY 8'h07
`define SFCT_CRC_INIT 8'h00
`define SFCT_ALARM_ADDR 7'h20
`define SFCT_CMD_READ 1'b1
`define SFCT_ERR_CNT_MAX 4'hF

`endif

// file: common/sfct_pkg.sv
// Types shared by the SPI frame and check target.
// Assumes nothing beyond the params header.
package sfct_pkg;
    typedef enum logic [1:0] {
        SFCT_IDLE,
        SFCT_EVAL,
        SFCT_RESP
    } sfct_state_t;
endpackage

// file: common/sfct_xfer_if.sv
// Signals passed between the core clock side and the SCLK side.
// Words are quasi-static: each side changes them only while chip
// select is in the state where the other side does not read them.
`timescale 1ns/1ps
`default_nettype none
interface sfct_xfer_if;
    logic [31:0] shift_word;
    logic [5:0] edge_cnt;
    logic [31:0] out_word;
    logic crc_en;
    logic fall_sel;
    logic out_dis;
    modport link (output shift_word, output edge_cnt, input out_word,
        input crc_en, input fall_sel, input out_dis);
    modport core (input shift_word, input edge_cnt, output out_word,
        output crc_en, output fall_sel, output out_dis);
endinterface
`default_nettype wire

// file: logic/sfct_link.sv
// SCLK-side shifter and serial output of the frame target.
// Assumes SCLK may run freely; chip select high masks every edge.
`timescale 1ns/1ps
`default_nettype none
`include "sfct_params.svh"
module sfct_link
    import sfct_pkg::*;
(
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic arst_n_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    sfct_xfer_if.link xf
);
    logic first_ff;
    logic [5:0] fall_cnt_ff;
    logic [5:0] rise_cnt_ff;
    logic [31:0] shift_ff;
    wire [5:0] frame_len;
    wire [5:0] fall_pos;
    wire [5:0] out_pos;
    wire [4:0] out_idx;
    wire delay_bit;

    // Preset by chip select high so the next frame restarts the count
    always_ff @(negedge sclk_i or posedge cs_n_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_ff <= 1'b1;
        end else if (cs_n_i) begin
            first_ff <= 1'b1;
        end else begin
            first_ff <= 1'b0;
        end
    end

    // Count holds through chip select high so the core can judge length
    always_ff @(negedge sclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fall_cnt_ff <= 6'h00;
        end else if (!cs_n_i) begin // [RULE_07]
            if (first_ff) begin
                fall_cnt_ff <= 6'h01; // [RULE_01]
            end else if (fall_cnt_ff != `SFCT_EDGE_MAX) begin
                fall_cnt_ff <= fall_cnt_ff + 6'h01;
            end
        end
    end

    always_ff @(negedge sclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_ff <= 32'h0000_0000;
        end else if (!cs_n_i) begin // [RULE_23]
            shift_ff <= {shift_ff[30:0], sdi_i}; // [RULE_01] [RULE_05]
        end
    end

    // Reset as well, so a count never starts unknown after power-up
    always_ff @(posedge sclk_i or posedge cs_n_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rise_cnt_ff <= 6'h00;
        end else if (cs_n_i) begin
            rise_cnt_ff <= 6'h00;
        end else if (rise_cnt_ff != `SFCT_EDGE_MAX) begin
            rise_cnt_ff <= rise_cnt_ff + 6'h01;
        end
    end

    assign frame_len = xf.crc_en ? `SFCT_FRAME_LONG : `SFCT_FRAME_SHORT;
    assign fall_pos = first_ff ? 6'h00 : fall_cnt_ff;
    assign out_pos = xf.fall_sel ? fall_pos : rise_cnt_ff; // [RULE_13]
    assign out_idx = 5'(6'd31 - out_pos); // [RULE_10]
    assign delay_bit = xf.crc_en ? shift_ff[31] : shift_ff[23]; // [RULE_08]

    // Position zero is shown as soon as chip select falls
    assign sdo_o = (out_pos < frame_len) ? xf.out_word[out_idx] // [RULE_13]
        : delay_bit; // [RULE_08]
    assign sdo_oe_o = !cs_n_i && !xf.out_dis; // [RULE_12] [RULE_07]

    assign xf.shift_word = shift_ff;
    assign xf.edge_cnt = fall_cnt_ff;
endmodule // sfct_link
`default_nettype wire

// file: logic/sfct_top.sv
// SPI frame target with check byte, error count and sticky fault.
// Assumes a register map on mclk_i that answers reads in the same
// cycle and supplies the configuration bits as plain levels.
// Operation
// RULE_01: Sample input bits on falling SCLK edges.
// RULE_02: Checked frame: R/W, address, data, check byte.
// RULE_03: Check disabled gives 24-bit frame.
// RULE_04: Short frames are discarded without effect.
// RULE_05: Only the last frame-length bits count.
// RULE_06: Frame takes effect at chip select rise.
// RULE_07: Chip select high blocks clock and data.
// RULE_08: Extra clocks echo input one frame late.
// RULE_09: Read ignores data; next frame returns value.
// RULE_10: Readback goes out MSB first.
// RULE_11: Write response: status, data, check byte.
// RULE_12: Output driven only when selected and enabled.
// RULE_13: First bit at select fall, then chosen edge.
// RULE_14: Output starts with command bit, status bits.
// RULE_15: Check polynomial is x8+x2+x+1.
// RULE_16: Output frame carries its own check byte.
// RULE_17: Bad remainder counts error, blocks command.
// RULE_18: Error limit sets sticky fault, alarm out.
// RULE_19: Frame error bit not sticky; fault sticky.
// RULE_20: Status read clears sticky, later re-latch.
// RULE_21: Frame effects cross into the core clock.
// RULE_22: Host keeps select high after config changes.
// RULE_23: Clock modes 1 and 2, free or gated.
// RULE_24: Check is MSB first, zero start, no inversion.
`timescale 1ns/1ps
`default_nettype none
`include "sfct_params.svh"
module sfct_top
    import sfct_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    input wire logic check_enable_i,
    input wire logic readback_output_disable_i,
    input wire logic readback_falling_edge_select_i,
    input wire logic [3:0] check_error_limit_i,
    input wire logic check_fault_mask_i,
    input wire logic alarm_action_en_i,
    input wire logic [4:0] status_i,
    output logic wr_valid_o,
    output logic [6:0] wr_addr_o,
    output logic [15:0] wr_data_o,
    output logic rd_valid_o,
    output logic [6:0] rd_addr_o,
    input wire logic [15:0] rd_data_i,
    output logic [3:0] check_error_counter_o,
    output logic check_fault_flag_o,
    output logic frame_error_o,
    output logic alarm_n_o
);
    sfct_xfer_if xf ();

    sfct_link u_link (
        .sclk_i(spi_sclk_i),
        .cs_n_i(spi_cs_n_i),
        .sdi_i(spi_sdi_i),
        .arst_n_i(arst_n_i),
        .sdo_o(spi_sdo_o),
        .sdo_oe_o(spi_sdo_oe_o),
        .xf(xf.link)
    );

    // MSB first, zero start, no final inversion
    function automatic logic [7:0] sfct_crc8(input logic [31:0] word,
        input logic [5:0] nbits);
        logic [7:0] rem;
        logic fb;
        rem = `SFCT_CRC_INIT; // [RULE_24]
        fb = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (6'(31 - i) < nbits) begin
                fb = rem[7] ^ word[i];
                rem = {rem[6:0], 1'b0};
                if (fb) begin
                    rem = rem ^ `SFCT_CRC_POLY; // [RULE_15]
                end
            end
        end
        return rem;
    endfunction

    sfct_state_t state_ff;
    sfct_state_t nxt_state;
    logic cs_meta_ff;
    logic cs_sync_ff;
    logic cs_prev_ff;
    logic crc_en_ff;
    logic fall_sel_ff;
    logic out_dis_ff;
    logic [31:0] out_word_ff;
    logic wr_valid_ff;
    logic [6:0] wr_addr_ff;
    logic [15:0] wr_data_ff;
    logic rd_valid_ff;
    logic [6:0] rd_addr_ff;
    logic [3:0] err_cnt_ff;
    logic fault_ff;
    logic crc_err_ff;
    logic cmd_bit_ff;
    logic resp_read_ff;
    logic alarm_n_ff;

    wire cs_rise;
    wire [5:0] frame_len;
    wire frame_full;
    wire [31:0] frame;
    wire rw_bit;
    wire [6:0] addr;
    wire [15:0] data;
    wire crc_bad;
    wire frame_good;
    wire limit_hit;
    wire alarm_read;
    wire fault_clr;
    wire alarm_irq;
    wire [7:0] status_byte;
    wire [15:0] resp_data;
    wire [23:0] resp_body;
    wire [7:0] resp_crc;

    // Chip select is the only frame event crossing in; the shift word
    // is stable by the time the synchronised rise is seen
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
        end else begin
            cs_meta_ff <= spi_cs_n_i; // [RULE_21]
            cs_sync_ff <= cs_meta_ff;
            cs_prev_ff <= cs_sync_ff;
        end
    end

    assign cs_rise = cs_sync_ff && !cs_prev_ff; // [RULE_06]

    // Link settings only change between frames, which keeps them
    // quasi-static for the SCLK side
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            crc_en_ff <= 1'b1;
            fall_sel_ff <= 1'b0;
            out_dis_ff <= 1'b1;
        end else if (cs_sync_ff) begin // [RULE_22]
            crc_en_ff <= check_enable_i; // [RULE_03]
            fall_sel_ff <= readback_falling_edge_select_i;
            out_dis_ff <= readback_output_disable_i;
        end
    end

    assign xf.crc_en = crc_en_ff;
    assign xf.fall_sel = fall_sel_ff;
    assign xf.out_dis = out_dis_ff;
    assign xf.out_word = out_word_ff;

    // Frame decode from the right-justified shift word
    assign frame_len = crc_en_ff ? `SFCT_FRAME_LONG : `SFCT_FRAME_SHORT;
    assign frame_full = xf.edge_cnt >= frame_len; // [RULE_04]
    assign frame = xf.shift_word; // [RULE_05]
    assign rw_bit = crc_en_ff ? frame[31] : frame[23]; // [RULE_02]
    assign addr = crc_en_ff ? frame[30:24] : frame[22:16]; // [RULE_02]
    assign data = crc_en_ff ? frame[23:8] : frame[15:0]; // [RULE_02]
    assign crc_bad = crc_en_ff
        && (sfct_crc8(frame, `SFCT_FRAME_LONG) != 8'h00); // [RULE_17]
    assign frame_good = frame_full && !crc_bad;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SFCT_IDLE: begin
                if (cs_rise) begin
                    nxt_state = SFCT_EVAL;
                end
            end
            SFCT_EVAL: begin
                nxt_state = frame_full ? SFCT_RESP : SFCT_IDLE; // [RULE_04]
            end
            SFCT_RESP: begin
                nxt_state = SFCT_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= SFCT_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Command strobes: one cycle, only for whole frames that checked out
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_valid_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
            wr_addr_ff <= 7'h00;
            wr_data_ff <= 16'h0000;
            rd_addr_ff <= 7'h00;
        end else begin
            wr_valid_ff <= (state_ff == SFCT_EVAL) && frame_good
                && (rw_bit != `SFCT_CMD_READ); // [RULE_11] [RULE_17]
            rd_valid_ff <= (state_ff == SFCT_EVAL) && frame_good
                && (rw_bit == `SFCT_CMD_READ); // [RULE_09] [RULE_17]
            // A read's data field is ignored, so the write side holds
            if ((state_ff == SFCT_EVAL) && frame_good
                && (rw_bit != `SFCT_CMD_READ)) begin
                wr_addr_ff <= addr;
                wr_data_ff <= data; // [RULE_09]
            end
            if ((state_ff == SFCT_EVAL) && frame_good
                && (rw_bit == `SFCT_CMD_READ)) begin
                rd_addr_ff <= addr;
            end
        end
    end

    // Per-frame facts for the next response
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            crc_err_ff <= 1'b0;
            cmd_bit_ff <= 1'b0;
            resp_read_ff <= 1'b0;
        end else if ((state_ff == SFCT_EVAL) && frame_full) begin
            crc_err_ff <= crc_bad; // [RULE_19] [RULE_14]
            cmd_bit_ff <= rw_bit; // [RULE_14]
            resp_read_ff <= !crc_bad && (rw_bit == `SFCT_CMD_READ);
        end
    end

    // Error count saturates so it cannot wrap below the limit
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_cnt_ff <= 4'h0;
        end else if ((state_ff == SFCT_EVAL) && frame_full && crc_bad) begin
            if (err_cnt_ff != `SFCT_ERR_CNT_MAX) begin
                err_cnt_ff <= err_cnt_ff + 4'h1; // [RULE_17]
            end
        end else if (fault_clr) begin
            err_cnt_ff <= 4'h0; // [RULE_20]
        end
    end

    // A count that the status read is clearing is stale, not a new fault
    assign limit_hit = (check_error_limit_i != 4'h0)
        && (err_cnt_ff >= check_error_limit_i)
        && !fault_clr; // [RULE_18] [RULE_20]
    assign alarm_read = (state_ff == SFCT_RESP) && resp_read_ff
        && (rd_addr_ff == `SFCT_ALARM_ADDR);
    assign fault_clr = alarm_read; // [RULE_19] [RULE_20]

    // The read clear wins, as limit_hit is masked while fault_clr is high
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_ff <= 1'b0;
        end else if (limit_hit) begin
            fault_ff <= 1'b1; // [RULE_18] [RULE_20]
        end else if (fault_clr) begin
            fault_ff <= 1'b0; // [RULE_19]
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alarm_n_ff <= 1'b1;
        end else begin
            alarm_n_ff <= !(fault_ff && alarm_action_en_i); // [RULE_18]
        end
    end

    // Response word: status byte, data, check byte, MSB aligned
    assign alarm_irq = fault_ff && !check_fault_mask_i; // [RULE_18]
    assign status_byte = {cmd_bit_ff, crc_err_ff, alarm_irq,
        status_i}; // [RULE_14]
    assign resp_data = !resp_read_ff ? wr_data_ff
        : alarm_read ? {rd_data_i[15:5], fault_ff, err_cnt_ff}
        : rd_data_i; // [RULE_09]
    assign resp_body = {status_byte, resp_data};
    assign resp_crc = crc_en_ff
        ? sfct_crc8({resp_body, 8'h00}, `SFCT_FRAME_SHORT) // [RULE_16]
        : 8'h00;

    // A short frame leaves the previous response in place
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_word_ff <= 32'h0000_0000;
        end else if (state_ff == SFCT_RESP) begin
            out_word_ff <= {resp_body, resp_crc}; // [RULE_11] [RULE_16]
        end
    end

    assign wr_valid_o = wr_valid_ff;
    assign wr_addr_o = wr_addr_ff;
    assign wr_data_o = wr_data_ff;
    assign rd_valid_o = rd_valid_ff;
    assign rd_addr_o = rd_addr_ff;
    assign check_error_counter_o = err_cnt_ff;
    assign check_fault_flag_o = fault_ff;
    assign frame_error_o = crc_err_ff;
    assign alarm_n_o = alarm_n_ff;
endmodule // sfct_top
`default_nettype wire

// file: dv/sfct_checker.sv
// Port-level timing checks for the SPI frame and check target.
// Assumes it is bound into sfct_top; all checks run on mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "sfct_params.svh"
module sfct_checker (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdo_oe_o,
    input wire logic alarm_action_en_i,
    input wire logic [3:0] check_error_limit_i,
    input wire logic wr_valid_o,
    input wire logic rd_valid_o,
    input wire logic [6:0] rd_addr_o,
    input wire logic [3:0] check_error_counter_o,
    input wire logic check_fault_flag_o,
    input wire logic frame_error_o,
    input wire logic alarm_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    wire logic at_lim = (check_error_limit_i != 4'h0)
        && (check_error_counter_o >= check_error_limit_i);
    AST_OE_IDLE: assert property (spi_cs_n_i |-> !spi_sdo_oe_o)
        else $error("sdo driven while deselected");
    AST_WR_PULSE: assert property (wr_valid_o |=> !wr_valid_o)
        else $error("write strobe longer than one cycle");
    AST_ONE_CMD: assert property (!(wr_valid_o && rd_valid_o))
        else $error("read and write strobes together");
    AST_AFTER_CS: assert property (
        (wr_valid_o || rd_valid_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
        else $error("command strobe before select rose");
    AST_CNT_STEP: assert property (
        $changed(check_error_counter_o) |-> check_error_counter_o == 4'h0
        || check_error_counter_o == $past(check_error_counter_o) + 4'h1)
        else $error("error count moved by other than one");
    AST_CNT_ERR: assert property (
        $changed(check_error_counter_o) && check_error_counter_o != 4'h0
        |-> ##[0:2] frame_error_o)
        else $error("count rose without frame error");
    AST_FAULT_SET: assert property (at_lim |-> ##[0:2] check_fault_flag_o)
        else $error("limit reached without fault");
    AST_FAULT_HOLD: assert property (
        $fell(check_fault_flag_o) |-> rd_addr_o == `SFCT_ALARM_ADDR
        && ($past(rd_valid_o) || $past(rd_valid_o, 2)
        || $past(rd_valid_o, 3)))
        else $error("fault cleared without alarm status read");
    AST_ALARM: assert property (
        alarm_n_o == !($past(check_fault_flag_o) && $past(alarm_action_en_i)))
        else $error("alarm pin does not follow fault");
    AST_ERR_CLEAR: assert property (
        (wr_valid_o || rd_valid_o) |-> ##[0:2] !frame_error_o)
        else $error("frame error kept after good frame");
    COV_WR: cover property (wr_valid_o);
    COV_RD_ALARM: cover property (rd_valid_o && rd_addr_o == `SFCT_ALARM_ADDR);
    COV_FAULT: cover property ($rose(check_fault_flag_o));
    COV_OE: cover property ($rose(spi_sdo_oe_o));
endmodule // sfct_checker
`default_nettype wire

// file: dv/sfct_host_model.sv
// Behavioural SPI host in clock mode 1 for the frame target.
// Assumes the bench calls xfer only while chip select is idle.
`timescale 1ns/1ps
`default_nettype none
module sfct_host_model (
    input wire logic sdo_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o
);
    // Gated clock: low between frames, never free running
    initial begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        sdi_o = 1'h0;
    end
    task automatic xfer(input logic [39:0] f, input int n,
            output logic [39:0] got);
        got = 40'h0;
        // Odd offset keeps SCLK and select edges off the core clock edges
        #7;
        cs_n_o = 1'h0;
        #20;
        for (int k = 0; k < n; k++) begin
            // Sampled just before launch, valid for either launch edge
            got[n-1-k] = sdo_i;
            sclk_o = 1'h1;
            sdi_o = f[n-1-k];
            #15;
            sclk_o = 1'h0;
            #15;
        end
        #10;
        cs_n_o = 1'h1;
        sdi_o = ~sdi_o;
        #150;
    endtask
endmodule // sfct_host_model
`default_nettype wire

// file: dv/spi_frame_crc_target_tb.sv
// Self-checking bench: host model, reference model and checker bind.
// Assumes design, host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "sfct_params.svh"
module spi_frame_crc_target_tb;
    logic mclk_i = 1'h0;
    logic arst_n_i = 1'h0;
    logic sclk, cs_n, sdi, sdo, sdo_oe, wr_v, rd_v, ferr, flt, alarm_n;
    logic tog = 1'h0, ce = 1'h1, dis = 1'h0, fsel = 1'h0;
    logic fmask = 1'h0, aen = 1'h1;
    logic [3:0] lim = 4'h2, cnt, m_cnt = 4'h0;
    logic [4:0] st = 5'h00;
    logic [6:0] wr_a, rd_a, m_wa = 7'h00, m_ra = 7'h00;
    logic [15:0] rdd = 16'h0000, wr_d, last_wr = 16'h0000;
    logic [31:0] exp_w = 32'h0, um = 32'h0;
    logic m_flt = 1'h0, m_err = 1'h0;
    int fails = 0, comparisons = 0, n_wr = 0, n_rd = 0, cyc = 0;
    int xw = 0, xr = 0;
    // Undriven line toggles so a stale value never looks valid
    wire logic sdo_w = sdo_oe ? sdo : tog;
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        tog <= ~tog;
        cyc <= cyc + 1;
        if (wr_v === 1'h1)
            n_wr <= n_wr + 1;
        if (rd_v === 1'h1)
            n_rd <= n_rd + 1;
        if (cs_n === 1'h0 && sdo_oe !== !dis) begin
            fails = fails + 1;
            $display("unexpected at %0t: sdo enable wrong", $time);
        end
        if (cyc == 8000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    sfct_host_model host (.sdo_i(sdo_w), .sclk_o(sclk), .cs_n_o(cs_n),
        .sdi_o(sdi));
    sfct_top dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe_o(sdo_oe), .check_enable_i(ce),
        .readback_output_disable_i(dis),
        .readback_falling_edge_select_i(fsel),
        .check_error_limit_i(lim), .check_fault_mask_i(fmask),
        .alarm_action_en_i(aen), .status_i(st), .wr_valid_o(wr_v),
        .wr_addr_o(wr_a), .wr_data_o(wr_d), .rd_valid_o(rd_v),
        .rd_addr_o(rd_a), .rd_data_i(rdd), .check_error_counter_o(cnt),
        .check_fault_flag_o(flt), .frame_error_o(ferr),
        .alarm_n_o(alarm_n));
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? `SFCT_CRC_POLY : 8'h00);
        return c;
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [39:0] f, input int n);
        logic [39:0] got, e, m;
        logic [31:0] fw;
        logic [15:0] dat;
        logic good, oflt;
        int len;
        len = ce ? 32 : 24;
        host.xfer(f, n, got);
        e = 40'h0;
        m = 40'h0;
        for (int k = 0; k < n; k++) begin
            e[n-1-k] = k < len ? exp_w[31-k] : f[n-1-k+len];
            m[n-1-k] = k < len ? ~um[31-k] : 1'h1;
        end
        if (!dis)
            chk(got & m, e & m);
        if (!dis && ce && n >= 32)
            chk(got[n-25 -: 8], crc8(got[n-1 -: 24]));
        if (n >= len) begin
            fw = ce ? f[31:0] : {f[23:0], 8'h00};
            good = !ce || crc8(fw[31:8]) == fw[7:0];
            oflt = m_flt;
            dat = last_wr;
            if (good && !fw[31]) begin
                xw++;
                last_wr = fw[23:8];
                m_wa = fw[30:24];
                dat = fw[23:8];
            end else if (good) begin
                xr++;
                m_ra = fw[30:24];
                dat = rdd;
                if (fw[30:24] == `SFCT_ALARM_ADDR) begin
                    dat = {rdd[15:5], m_flt, m_cnt};
                    m_flt = 1'h0;
                    m_cnt = 4'h0;
                end
            end else begin
                m_cnt = m_cnt == 4'hF ? m_cnt : m_cnt + 4'h1;
                if (lim != 4'h0 && m_cnt >= lim)
                    m_flt = 1'h1;
            end
            m_err = !good;
            exp_w = {fw[31], !good, m_flt & !fmask, st, dat, 8'h00};
            if (ce)
                exp_w[7:0] = crc8(exp_w[31:8]);
            // Alarm flag may land one frame late when the fault flips
            um = oflt != m_flt ? 32'h200000FF : 32'h0;
        end
        chk(xw * 256 + xr, n_wr * 256 + n_rd);
        chk({cnt, flt, ferr, alarm_n}, {m_cnt, m_flt, m_err, !(m_flt & aen)});
        chk({wr_a, wr_d, rd_a}, {m_wa, last_wr, m_ra});
    endtask
    initial begin
        int seed;
        int n;
        logic [23:0] w;
        logic [39:0] f;
        seed = $urandom(82367);
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'h1;
        repeat (10) @(posedge mclk_i);
        for (int i = 0; i < 26; i++) begin
            @(posedge mclk_i);
            st <= 5'($urandom);
            rdd <= 16'($urandom);
            fsel <= i >= 14;
            dis <= i == 18;
            ce <= i < 20;
            fmask <= i >= 18;
            aen <= i < 22;
            repeat (3) @(posedge mclk_i);
            w = 24'($urandom);
            if (w[22:16] == `SFCT_ALARM_ADDR)
                w[16] = ~w[16];
            if (i == 10)
                w = {1'h1, `SFCT_ALARM_ADDR, w[15:0]};
            f = {16'h0, w};
            if (ce)
                f = {8'h0, w, crc8(w) ^ {7'h0, i == 6 || i == 7
                    || i == 15 || i == 16}};
            n = ce ? 32 : 24;
            if (i == 8 || i == 23)
                n = n - 4;
            if (i == 9) begin
                f[33:32] = 2'h2;
                n = 34;
            end
            frame(f, n);
        end
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
endmodule // spi_frame_crc_target_tb
bind sfct_top sfct_checker chk_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .spi_cs_n_i(spi_cs_n_i), .spi_sdo_oe_o(spi_sdo_oe_o),
    .alarm_action_en_i(alarm_action_en_i),
    .check_error_limit_i(check_error_limit_i), .wr_valid_o(wr_valid_o),
    .rd_valid_o(rd_valid_o), .rd_addr_o(rd_addr_o),
    .check_error_counter_o(check_error_counter_o),
    .check_fault_flag_o(check_fault_flag_o),
    .frame_error_o(frame_error_o), .alarm_n_o(alarm_n_o));
`default_nettype wire
